/* verilog/ipm_map.svh */
// Constants for the input pair mode decoder: word layout, selectors, resets, read addresses.
// Assumes it is included by bare name from files that also import ipm_pkg.
`ifndef IPM_MAP_SVH
`define IPM_MAP_SVH

`define IPM_SEL_HI      15
`define IPM_SEL_LO      11
`define IPM_UNI_SEL     5'h11
`define IPM_BIP_SEL     5'h12
`define IPM_PAIR_HI     10
`define IPM_PAIR_LO     3
`define IPM_COM_BIT     2
`define IPM_PAIR_RST    8'h00
`define IPM_COM_RST     1'b0
`define IPM_SHARED_CH   4'hF
`define IPM_GND_CH      4'h0
`define IPM_ADDR_UNI    4'h0
`define IPM_ADDR_BIP    4'h1
`define IPM_ADDR_STAT   4'h2

`endif

/* verilog/ipm_pkg.sv */
// Types shared by the input pair mode decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package ipm_pkg;
  // Input configuration chosen for one conversion
  typedef enum logic [1:0] {
    ipm_single,
    ipm_diff,
    ipm_common
  } ipm_mode_t;
endpackage : ipm_pkg

/* verilog/ipm_pair_decode.sv */
// Combinational decode of one channel's pair bits into input configuration and coding.
// Assumes the caller has already picked the pair bits that belong to the channel.
`timescale 1ns/10ps
`include "ipm_map.svh"
module ipm_pair_decode
  import ipm_pkg::*;
(
  input  wire logic [3:0] chan,
  input  wire logic       uni_bit,
  input  wire logic       bip_bit,
  input  wire logic       com_en,
  output ipm_mode_t       mode,
  output logic            twos,
  output logic [3:0]      pos_ch,
  output logic [3:0]      neg_ch
);
  // Common reference covers inputs below the shared one; it is the shared pin itself
  wire       use_com  = com_en && (chan != `IPM_SHARED_CH);
  // Unipolar bit takes precedence over bipolar bit
  wire       use_diff = uni_bit || bip_bit;
  wire [3:0] even_ch  = {chan[3:1], 1'b0};
  wire [3:0] odd_ch   = {chan[3:1], 1'b1};

  // Priority: common reference, then pair, then single-ended
  assign mode   = use_com ? ipm_common : (use_diff ? ipm_diff : ipm_single);
  assign twos   = !use_com && !uni_bit && bip_bit;
  assign pos_ch = (use_com || !use_diff) ? chan : even_ch;
  assign neg_ch = use_com ? `IPM_SHARED_CH : (use_diff ? odd_ch : `IPM_GND_CH);
endmodule : ipm_pair_decode

/* verilog/ipm_decoder.sv */
// Input pair mode decoder: holds pair and common-reference settings, decodes per conversion.
// Assumes a configuration port with one-cycle strobes and a one-cycle conversion start pulse.
`timescale 1ns/10ps
`include "ipm_map.svh"
module ipm_decoder
  import ipm_pkg::*;
#(
  parameter int NUM_CH = 16
)
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  cfg_addr,
  input  wire logic [15:0] cfg_wdata,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  output logic [15:0]      cfg_rdata,
  input  wire logic        conv_start,
  input  wire logic [3:0]  channel_select_field,
  output logic             conv_taken,
  output ipm_mode_t        conv_mode,
  output logic             conv_twos,
  output logic [3:0]       conv_pos_ch,
  output logic [3:0]       conv_neg_ch
);
  localparam int NUM_PAIRS = 8;

  // Word layout holds eight pairs; odd counts would split a pair, so refuse them at elaboration
  if (NUM_CH < 2 || NUM_CH > 16 || (NUM_CH % 2) != 0) begin : g_bad_num_ch
    $error("ipm_decoder: NUM_CH must be even and between 2 and 16");
  end

  // Pair p sits at word bit 10-p, so raw index is 7-p
  function automatic logic pair_bit(input logic [7:0] raw, input logic [3:0] ch);
    logic [2:0] idx;
    idx = 3'(NUM_PAIRS - 1) - ch[3:1];
    return raw[idx];
  endfunction : pair_bit

  logic [7:0]  uni_pairs_r;
  logic [7:0]  uni_pairs_nxt;
  logic [7:0]  bip_pairs_r;
  logic [7:0]  bip_pairs_nxt;
  logic        common_reference_enable_r;
  logic        common_reference_enable_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        taken_r;
  ipm_mode_t   mode_r;
  logic        twos_r;
  logic [3:0]  pos_r;
  logic [3:0]  neg_r;

  // Selector decode of the incoming configuration word
  wire [4:0] word_sel              = cfg_wdata[`IPM_SEL_HI:`IPM_SEL_LO];
  wire       unipolar_word_selector = cfg_wr && (word_sel == `IPM_UNI_SEL);
  wire       bipolar_word_selector  = cfg_wr && (word_sel == `IPM_BIP_SEL);

  // Next register values; other selectors belong to other blocks and are ignored here
  assign uni_pairs_nxt = unipolar_word_selector ? cfg_wdata[`IPM_PAIR_HI:`IPM_PAIR_LO] : uni_pairs_r;
  assign bip_pairs_nxt = bipolar_word_selector ? cfg_wdata[`IPM_PAIR_HI:`IPM_PAIR_LO] : bip_pairs_r;
  assign common_reference_enable_nxt = unipolar_word_selector ? cfg_wdata[`IPM_COM_BIT]
                                                              : common_reference_enable_r;

  // Configuration storage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      uni_pairs_r               <= `IPM_PAIR_RST;
      bip_pairs_r               <= `IPM_PAIR_RST;
      common_reference_enable_r <= `IPM_COM_RST;
    end else begin
      uni_pairs_r               <= uni_pairs_nxt;
      bip_pairs_r               <= bip_pairs_nxt;
      common_reference_enable_r <= common_reference_enable_nxt;
    end
  end

  // Per-channel bit pick, same pattern for every pair
  wire pair_unipolar_diff_bit = pair_bit(uni_pairs_r, channel_select_field);
  wire pair_bipolar_diff_bit  = pair_bit(bip_pairs_r, channel_select_field);

  ipm_mode_t dec_mode;
  logic      dec_twos;
  logic [3:0] dec_pos;
  logic [3:0] dec_neg;

  ipm_pair_decode u_dec (
    .chan    (channel_select_field),
    .uni_bit (pair_unipolar_diff_bit),
    .bip_bit (pair_bipolar_diff_bit),
    .com_en  (common_reference_enable_r),
    .mode    (dec_mode),
    .twos    (dec_twos),
    .pos_ch  (dec_pos),
    .neg_ch  (dec_neg)
  );

  // Snapshot at start; a write in the same cycle lands only for the next conversion
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      taken_r <= 1'b0;
      mode_r  <= ipm_single;
      twos_r  <= 1'b0;
      pos_r   <= 4'h0;
      neg_r   <= 4'h0;
    end else begin
      taken_r <= conv_start;
      if (conv_start) begin
        mode_r <= dec_mode;
        twos_r <= dec_twos;
        pos_r  <= dec_pos;
        neg_r  <= dec_neg;
      end
    end
  end

  // Readback mux; data stands only in the cycle after the read strobe
  wire [15:0] uni_word  = {`IPM_UNI_SEL, uni_pairs_r, common_reference_enable_r, 2'b00};
  wire [15:0] bip_word  = {`IPM_BIP_SEL, bip_pairs_r, 3'b000};
  wire [15:0] stat_word = {5'h00, mode_r, twos_r, pos_r, neg_r};
  assign rdata_nxt = !cfg_rd                      ? 16'h0000 :
                     (cfg_addr == `IPM_ADDR_UNI)  ? uni_word :
                     (cfg_addr == `IPM_ADDR_BIP)  ? bip_word :
                     (cfg_addr == `IPM_ADDR_STAT) ? stat_word : 16'h0000;

  // Read data register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cfg_rdata   = rdata_r;
  assign conv_taken  = taken_r;
  assign conv_mode   = mode_r;
  assign conv_twos   = twos_r;
  assign conv_pos_ch = pos_r;
  assign conv_neg_ch = neg_r;

  // Start with every configuration bit of the channel clear
  sequence s_start_plain;
    conv_start && !common_reference_enable_r && !pair_unipolar_diff_bit && !pair_bipolar_diff_bit
      && !cfg_wr;
  endsequence
  // Start with common reference active on a non-shared channel
  sequence s_start_common;
    conv_start && common_reference_enable_r && channel_select_field != `IPM_SHARED_CH;
  endsequence

  a_uni_word_write: assert property (@(posedge core_clk) disable iff (!nrst)
    unipolar_word_selector |=> uni_pairs_r == $past(cfg_wdata[10:3]) && $stable(bip_pairs_r))
    else $error("unipolar word not stored");

  a_bip_word_write: assert property (@(posedge core_clk) disable iff (!nrst)
    bipolar_word_selector |=> bip_pairs_r == $past(cfg_wdata[10:3]) && $stable(uni_pairs_r)
      && $stable(common_reference_enable_r))
    else $error("bipolar word not stored");

  a_com_bit_pos: assert property (@(posedge core_clk) disable iff (!nrst)
    unipolar_word_selector ##1 cfg_rd && cfg_addr == 4'h0 |=>
      cfg_rdata[2] == $past(cfg_wdata[2], 2))
    else $error("common reference bit not at bit 2");

  a_single_ended: assert property (@(posedge core_clk) disable iff (!nrst)
    s_start_plain |=> conv_mode == ipm_single && !conv_twos && conv_pos_ch == $past(channel_select_field))
    else $error("plain start not single-ended binary");

  a_bipolar_pair: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_start && !common_reference_enable_r && !pair_unipolar_diff_bit && pair_bipolar_diff_bit
      |=> conv_mode == ipm_diff && conv_twos && conv_neg_ch == {conv_pos_ch[3:1], 1'b1})
    else $error("bipolar pair decode wrong");

  a_unipolar_pair: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_start && !common_reference_enable_r && pair_unipolar_diff_bit
      |=> conv_mode == ipm_diff && !conv_twos && conv_pos_ch[0] == 1'b0 && conv_neg_ch[0] == 1'b1)
    else $error("unipolar pair decode wrong");

  a_common_ref: assert property (@(posedge core_clk) disable iff (!nrst)
    s_start_common |=> conv_mode == ipm_common && !conv_twos && conv_neg_ch == 4'hF
      && conv_pos_ch == $past(channel_select_field))
    else $error("common reference decode wrong");

  a_snapshot_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !conv_start |=> $stable(conv_mode) && $stable(conv_pos_ch) && $stable(conv_twos) && !conv_taken)
    else $error("conversion setup changed without start");

  a_read_window: assert property (@(posedge core_clk) disable iff (!nrst)
    !cfg_rd |=> cfg_rdata == 16'h0000)
    else $error("read data outside read window");

  // Further handshake, decode, storage and readback checks, all on core_clk with reset released
  a_start_taken: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_start |=> conv_taken)
    else $error("start not acknowledged");

  a_refused_word: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_wr && !unipolar_word_selector && !bipolar_word_selector |=> $stable(uni_pairs_r)
      && $stable(bip_pairs_r) && $stable(common_reference_enable_r))
    else $error("foreign word changed settings");

  a_shared_no_common: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_start && channel_select_field == `IPM_SHARED_CH |=> conv_mode != ipm_common)
    else $error("shared input referred to itself");

  a_single_ground: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_start && !pair_unipolar_diff_bit && !pair_bipolar_diff_bit
      && (!common_reference_enable_r || channel_select_field == `IPM_SHARED_CH)
      |=> conv_mode == ipm_single && conv_neg_ch == `IPM_GND_CH)
    else $error("single-ended negative input not ground");

  a_pair_even_pos: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_start && !common_reference_enable_r && (pair_unipolar_diff_bit || pair_bipolar_diff_bit)
      |=> conv_pos_ch == {$past(channel_select_field[3:1]), 1'b0})
    else $error("pair positive input not even member");

  a_uni_readback: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_rd && cfg_addr == `IPM_ADDR_UNI |=> cfg_rdata[`IPM_SEL_HI:`IPM_SEL_LO] == `IPM_UNI_SEL
      && cfg_rdata[`IPM_PAIR_HI:`IPM_PAIR_LO] == $past(uni_pairs_r))
    else $error("unipolar readback wrong");

  a_bip_readback: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_rd && cfg_addr == `IPM_ADDR_BIP |=> cfg_rdata == {`IPM_BIP_SEL, $past(bip_pairs_r), 3'b000})
    else $error("bipolar readback wrong");
endmodule : ipm_decoder

/* verification/ipm_host_model.sv */
// Host side of the configuration port: issues single-cycle writes and reads.
// Assumes the bench calls one task at a time, after reset has been released.
`timescale 1ns/10ps
module ipm_host_model (
  input  wire logic        core_clk,
  output logic [3:0]       cfg_addr,
  output logic [15:0]      cfg_wdata,
  output logic             cfg_wr,
  output logic             cfg_rd,
  input  wire logic [15:0] cfg_rdata
);
  // Idle bus at time zero
  initial begin
    cfg_addr = 4'h0;
    cfg_wdata = 16'h0000;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
  end
  // Word selector rides in the top five bits; data inverted after use so stale values never look valid
  task automatic wr(input logic [15:0] w);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= w;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~w;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    #1;
    d = cfg_rdata;
  endtask : rd
  // Write, then a read on the very next cycle with no idle gap between the strobes
  task automatic wr_rd(input logic [15:0] w, input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= w;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~w;
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    #1;
    d = cfg_rdata;
  endtask : wr_rd
endmodule : ipm_host_model

/* verification/testbench.sv */
// Self-checking bench: random writes race conversions, decode compared with a reference model.
// Assumes ipm_decoder with NUM_CH of 16 and the host model on its register port.
`timescale 1ns/10ps
module testbench;
  import ipm_pkg::*;
  logic        core_clk, nrst, cfg_wr, cfg_rd, conv_start, conv_taken, conv_twos, com_q;
  logic [3:0]  cfg_addr, channel_select_field, conv_pos_ch, conv_neg_ch;
  logic [15:0] cfg_wdata, cfg_rdata, w, d;
  logic [7:0]  uni_q, bip_q;
  logic [11:0] exp_conv;
  logic [11:0] exp_q[$];
  ipm_mode_t   conv_mode;
  int          miscompares, total_checks, seed, i, r;

  ipm_decoder #(.NUM_CH(16)) uut (.core_clk(core_clk), .nrst(nrst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .conv_start(conv_start), .channel_select_field(channel_select_field), .conv_taken(conv_taken),
    .conv_mode(conv_mode), .conv_twos(conv_twos), .conv_pos_ch(conv_pos_ch), .conv_neg_ch(conv_neg_ch));
  ipm_host_model host (.core_clk(core_clk), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata));

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  // Reference decode, packed as taken, mode, twos, positive, negative; common wins, then unipolar
  function automatic logic [11:0] dec(input int c);
    if (com_q && c != 15) return {3'h6, 1'b0, 4'(c), 4'hF};
    if (uni_q[7 - c / 2]) return {3'h5, 1'b0, 4'(c & 14), 4'(c | 1)};
    if (bip_q[7 - c / 2]) return {3'h5, 1'b1, 4'(c & 14), 4'(c | 1)};
    return {3'h4, 1'b0, 4'(c), 4'h0};
  endfunction : dec

  task automatic chk_conv(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t conv got %h exp %h", $time, got, exp);
    end
  endtask : chk_conv

  task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t read got %h exp %h", $time, got, exp);
    end
  endtask : chk_rd

  // Conversion start pulse; outputs settle one cycle later
  task automatic conv(input int c);
    @(posedge core_clk);
    conv_start <= 1'b1;
    channel_select_field <= 4'(c);
    @(posedge core_clk);
    conv_start <= 1'b0;
    channel_select_field <= ~4'(c);
    #1;
  endtask : conv

  // Readback of both words, status and one unmapped address
  task automatic rd_all;
    host.rd(4'h0, d);
    chk_rd(d, {5'h11, uni_q, com_q, 2'h0});
    host.rd(4'h1, d);
    chk_rd(d, {5'h12, bip_q, 3'h0});
    host.rd(4'h2, d);
    chk_rd(d, {5'h00, exp_conv[10:0]});
    host.rd(4'(r[11:8]) | 4'h3, d);
    chk_rd(d, 16'h0000);
  endtask : rd_all

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Main sequence: write and conversion in the same cycle must use the old settings
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    conv_start = 1'b0;
    channel_select_field = 4'h0;
    seed = 72;
    uni_q = 8'h00;
    bip_q = 8'h00;
    com_q = 1'b0;
    exp_conv = 12'h000;
    r = 0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rd_all();
    for (i = 0; i < 200; i++) begin
      r = $random(seed);
      w = {(r[1:0] == 2'h0) ? 5'h13 : (r[0] ? 5'h11 : 5'h12), 11'($random(seed))};
      exp_q.push_back(dec(int'(r[7:4])));
      fork
        host.wr(w);
        conv(int'(r[7:4]));
      join
      exp_conv = exp_q.pop_front();
      chk_conv({conv_taken, conv_mode, conv_twos, conv_pos_ch, conv_neg_ch}, exp_conv);
      if (w[15:11] == 5'h11) begin
        uni_q = w[10:3];
        com_q = w[2];
      end
      else if (w[15:11] == 5'h12) bip_q = w[10:3];
      rd_all();
    end
    // Back-to-back write and read of the unipolar word
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      w = {5'h11, 11'(r)};
      host.wr_rd(w, 4'h0, d);
      uni_q = w[10:3];
      com_q = w[2];
      chk_rd(d, {5'h11, uni_q, com_q, 2'h0});
    end
    // Mid-run reset must clear pair and common-reference settings
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    uni_q = 8'h00;
    bip_q = 8'h00;
    com_q = 1'b0;
    exp_conv = 12'h000;
    rd_all();
    conv(0);
    chk_conv({conv_taken, conv_mode, conv_twos, conv_pos_ch, conv_neg_ch}, dec(0));
    conv(1);
    chk_conv({conv_taken, conv_mode, conv_twos, conv_pos_ch, conv_neg_ch}, dec(1));
    close_out();
  end

  // Watchdog, well beyond the expected 2000 cycles
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule : testbench
